//--- bank_addr_resolve.sv
// turns a direct or indirect file reference into a full data-memory address
`default_nettype none

module bank_addr_resolve
	import sfr_bank_pkg::*;
(
	input wire logic use_instr, // reference comes from an instruction
	input wire logic [6:0] file_addr, // instruction file field
	input wire logic [8:0] bus_index, // full index from the bus
	input wire logic [1:0] bank_sel, // direct bank select bits
	input wire logic indirect_bank, // indirect bank select bit
	input wire logic [7:0] pointer, // indirect pointer register
	output logic [8:0] eff_addr, // resolved address
	output logic eff_null // indirect loop onto the port itself
);

	logic [8:0] base;
	logic via_port;

	// bank select bits pick one of four 128-byte banks
	assign base = use_instr ? {bank_sel, file_addr} : bus_index;
	assign via_port = (base[6:0] == PORT_LOW7);
	// the port holds nothing, it redirects to the pointed location
	assign eff_addr = via_port ? {indirect_bank, pointer} : base;
	assign eff_null = via_port && (pointer[6:0] == PORT_LOW7);

endmodule : bank_addr_resolve

`default_nettype wire

//--- core_status_and_sfr_bank.sv
// apb-reached sfr bank with the core status register and instruction port
//
// How it works
// - status holds flags, reset cause, bank bits
// - any file-writing instruction may target the status register
// - flag instructions override written Z, DC, C
// - watchdog and sleep flags ignore writes
// - clear on status: banks zero, Z set
// - bit, swap, move instructions keep all flags unless they write status
// - subtraction carries are inverted borrows
// - unimplemented locations and bits read zero
// - status mirrored at same offset, all banks
// - two bank bits select four banks
`default_nettype none

module core_status_and_sfr_bank
	import sfr_bank_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset
	input wire logic psel, // slave select
	input wire logic penable, // access phase
	input wire logic pwrite, // write when high
	input wire logic [ADDR_W-1:0] paddr, // byte address
	input wire logic [DATA_W-1:0] pwdata, // write data
	input wire logic watchdog_timeout, // watchdog expired
	input wire logic sleep_enter, // core enters sleep
	input wire logic watchdog_clear, // watchdog cleared
	output logic [DATA_W-1:0] prdata, // read data
	output logic pready, // transfer done
	output logic pslverr, // unmapped or misaligned
	output status_s status_out // live status register
);

	// ==========================================================
	// bus decode
	logic [9:0] idx;
	logic xfer;
	logic is_data;
	logic is_instr;
	logic is_working;
	logic bad_addr;
	instr_s ins;
	logic exec;

	assign idx = paddr[ADDR_W-1:2];
	assign is_data = (idx < IDX_DATA_END);
	assign is_instr = (idx == IDX_INSTR);
	assign is_working = (idx == IDX_WORKING);
	assign bad_addr = (paddr[1:0] != WORD_ALIGN) || !(is_data || is_instr || is_working);
	assign xfer = psel && penable && pready;
	assign ins = instr_s'(pwdata[INSTR_W-1:0]);
	assign exec = xfer && pwrite && is_instr && !bad_addr;

	// ==========================================================
	// state
	status_s status_reg;
	status_s status_next;
	logic [7:0] sfr_reg [SFR_NUM];
	logic [7:0] w_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [DATA_W-1:0] prdata_reg;

	// ==========================================================
	// address resolution
	logic [8:0] eff_addr;
	logic eff_null;
	logic sfr_hit;
	logic status_hit;

	bank_addr_resolve u_resolve (
		.use_instr(is_instr),
		.file_addr(ins.file_addr),
		.bus_index(idx[8:0]),
		.bank_sel({status_reg.direct_bank_select_high, status_reg.direct_bank_select_low}),
		.indirect_bank(status_reg.indirect_bank_select),
		.pointer(sfr_reg[SLOT_POINTER]),
		.eff_addr(eff_addr),
		.eff_null(eff_null)
	);

	// one physical status register answers in every bank
	assign status_hit = !eff_null && (eff_addr[6:0] == STATUS_LOW7);
	assign sfr_hit = !eff_null && !status_hit && (eff_addr[8:4] == SFR_BASE[8:4])
		&& (eff_addr[3:0] <= SFR_LAST);

	// ==========================================================
	// file read
	logic [7:0] rd_file;

	always_comb begin
		rd_file = BYTE_ZERO;
		if (status_hit) begin
			rd_file = status_reg;
		end else if (sfr_hit) begin
			rd_file = sfr_reg[eff_addr[3:0]] & SFR_MASK[eff_addr[3:0]];
		end
	end

	// ==========================================================
	// instruction execution
	logic [7:0] alu_a;
	logic alu_sub;
	logic [7:0] alu_sum;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic [7:0] result;
	logic writes_file;
	logic writes_w;
	logic [2:0] flag_mask;
	logic [7:0] bit_mask;

	assign alu_a = (ins.op == OP_SUBTRACT_LITERAL) ? ins.literal : rd_file;
	assign alu_sub = (ins.op == OP_SUBTRACT_FILE) || (ins.op == OP_SUBTRACT_LITERAL);
	assign bit_mask = 8'h01 << ins.bit_sel;

	flag_alu u_alu (
		.a(alu_a),
		.b(w_reg),
		.subtract(alu_sub),
		.sum(alu_sum),
		.carry(alu_c),
		.digit_carry(alu_dc),
		.zero(alu_z)
	);

	// flag_mask order: zero, digit carry, carry
	always_comb begin
		result = alu_sum;
		writes_file = ins.to_file;
		writes_w = !ins.to_file;
		flag_mask = 3'b000;
		unique case (ins.op)
			OP_MOVE_LITERAL: begin
				result = ins.literal;
				writes_file = 1'b0;
				writes_w = 1'b1;
			end
			OP_MOVE_W_TO_FILE: begin
				result = w_reg;
				writes_file = 1'b1;
				writes_w = 1'b0;
			end
			OP_CLEAR_FILE: begin
				result = BYTE_ZERO;
				writes_file = 1'b1;
				writes_w = 1'b0;
				flag_mask = 3'b100;
			end
			OP_ADD_FILE, OP_SUBTRACT_FILE: begin
				flag_mask = 3'b111;
			end
			OP_SUBTRACT_LITERAL: begin
				writes_file = 1'b0;
				writes_w = 1'b1;
				flag_mask = 3'b111;
			end
			OP_BIT_CLEAR: begin
				result = rd_file & ~bit_mask;
				writes_file = 1'b1;
				writes_w = 1'b0;
			end
			OP_BIT_SET: begin
				result = rd_file | bit_mask;
				writes_file = 1'b1;
				writes_w = 1'b0;
			end
			OP_NIBBLE_SWAP: begin
				result = {rd_file[3:0], rd_file[7:4]};
			end
			default: begin
				writes_file = 1'b0;
				writes_w = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// write path
	logic file_we;
	logic [7:0] wdata;

	// a port access whose pointer loops back onto the port location writes nothing
	assign file_we = !eff_null && ((xfer && pwrite && is_data && !bad_addr)
		|| (exec && writes_file));
	assign wdata = is_instr ? result : pwdata[7:0];

	for (genvar i = 0; i < SFR_NUM; i++) begin : g_sfr
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sfr_reg[i] <= SFR_RESET[i];
			end else if (file_we && sfr_hit && eff_addr[3:0] == 4'(i)) begin
				sfr_reg[i] <= wdata & SFR_MASK[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg <= BYTE_ZERO;
		end else if (xfer && pwrite && is_working && !bad_addr) begin
			w_reg <= pwdata[7:0];
		end else if (exec && writes_w) begin
			w_reg <= result;
		end
	end

	// ==========================================================
	// core status
	always_comb begin
		status_next = status_reg;
		if (file_we && status_hit) begin
			status_next = status_s'(wdata);
			status_next.watchdog_expiry_flag = status_reg.watchdog_expiry_flag;
			status_next.sleep_entry_flag = status_reg.sleep_entry_flag;
			// a flag-changing instruction loses its written flag bits
			if (is_instr && flag_mask != 3'b000) begin
				status_next.zero_flag = status_reg.zero_flag;
				status_next.nibble_overflow_flag = status_reg.nibble_overflow_flag;
				status_next.carry_flag = status_reg.carry_flag;
			end
		end
		if (exec) begin
			if (flag_mask[2]) begin
				status_next.zero_flag = (result == BYTE_ZERO);
			end
			if (flag_mask[1]) begin
				status_next.nibble_overflow_flag = alu_dc;
			end
			if (flag_mask[0]) begin
				status_next.carry_flag = alu_c;
			end
		end
		// only reset, watchdog and sleep events move the cause flags
		if (watchdog_timeout) begin
			status_next.watchdog_expiry_flag = 1'b0;
		end else if (sleep_enter) begin
			status_next.watchdog_expiry_flag = 1'b1;
			status_next.sleep_entry_flag = 1'b0;
		end else if (watchdog_clear) begin
			status_next.watchdog_expiry_flag = 1'b1;
			status_next.sleep_entry_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= status_s'(STATUS_RESET);
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// apb answer: one wait state, read data captured with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && bad_addr;
			if (psel && penable && !pready_reg && !pwrite) begin
				if (bad_addr) begin
					prdata_reg <= '0;
				end else if (is_data) begin
					prdata_reg <= {24'h000000, rd_file};
				end else if (is_working) begin
					prdata_reg <= {24'h000000, w_reg};
				end else begin
					prdata_reg <= '0;
				end
			end
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	assign status_out = status_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic no_event;
	assign no_event = !watchdog_timeout && !sleep_enter && !watchdog_clear;

	a_status_mirror: assert property (xfer && !pwrite && is_data && !bad_addr
		&& idx[6:0] == STATUS_LOW7 |-> prdata_reg[7:0] == $past(status_reg))
		else $error("status mirror read mismatch");

	a_cause_protect: assert property (xfer && pwrite && no_event |=>
		$stable({status_reg.watchdog_expiry_flag, status_reg.sleep_entry_flag}))
		else $error("protected flag changed by write");

	a_clear_status: assert property (exec && ins.op == OP_CLEAR_FILE && status_hit && no_event
		|=> status_reg[7:5] == 3'b000 && status_reg.zero_flag
		&& $stable(status_reg[4:3]) && $stable(status_reg[1:0]))
		else $error("clear on status gave wrong value");

	a_flag_override: assert property (exec && status_hit && ins.to_file
		&& (ins.op == OP_ADD_FILE || ins.op == OP_SUBTRACT_FILE)
		|=> status_reg.carry_flag == $past(alu_c)
		&& status_reg.zero_flag == $past(alu_z))
		else $error("written flags not overridden");

	a_bitops_keep: assert property (exec && !status_hit && (ins.op == OP_BIT_CLEAR
		|| ins.op == OP_BIT_SET || ins.op == OP_NIBBLE_SWAP || ins.op == OP_MOVE_W_TO_FILE)
		|=> $stable(status_reg[2:0]))
		else $error("flag moved by flag-neutral op");

	a_sub_borrow: assert property (exec && ins.op == OP_SUBTRACT_LITERAL
		|=> status_reg.carry_flag == ($past(ins.literal) >= $past(w_reg)))
		else $error("subtract carry not inverted borrow");

	a_unimpl_zero: assert property (xfer && !pwrite && !bad_addr |->
		prdata_reg[31:8] == 24'h000000)
		else $error("unimplemented bits not zero");

	a_bank_direct: assert property (exec && ins.op == OP_MOVE_W_TO_FILE
		&& ins.file_addr == IDX_INDIRECT_POINTER[6:0]
		&& status_reg[6:5] == IDX_INDIRECT_POINTER[8:7]
		|=> sfr_reg[SLOT_POINTER] == $past(w_reg))
		else $error("bank select did not reach bank three");

	a_port_redirect: assert property (exec && ins.op == OP_MOVE_W_TO_FILE
		&& ins.file_addr == PORT_LOW7
		&& {status_reg.indirect_bank_select, sfr_reg[SLOT_POINTER]} == IDX_PIN_DIRECTION_B
		|=> sfr_reg[SLOT_DIRECTION_B] == $past(w_reg))
		else $error("port write not redirected");

	c_clear_status: cover property (exec && ins.op == OP_CLEAR_FILE && status_hit);
	c_sub_literal: cover property (exec && ins.op == OP_SUBTRACT_LITERAL);
	c_port_access: cover property (exec && ins.file_addr == PORT_LOW7 && !eff_null);
	c_watchdog: cover property (watchdog_timeout ##1 xfer && !pwrite && status_hit);

endmodule : core_status_and_sfr_bank

`default_nettype wire

//--- core_status_and_sfr_bank_bench.sv
// self-checking bench for the core status and sfr bank
`default_nettype none

module core_status_and_sfr_bank_bench
	import sfr_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========
	// signals and model state
	logic pclk, presetn, psel, penable, pwrite, wd_to, sl_en, wd_cl, pready, pslverr, errv;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdv;
	status_s status_out;
	logic [7:0] st, w, a, b, r8;
	logic [2:0] f;
	int n_mismatch, n_checks;
	logic [9:0] ri [8] = '{10'h181, 10'h182, 10'h183, 10'h184, 10'h186, 10'h18A, 10'h18B, 10'h201};
	logic [7:0] rv [8] = '{8'hFF, 8'h00, 8'h18, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

	core_status_and_sfr_bank u_core_status_and_sfr_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .watchdog_timeout(wd_to),
		.sleep_enter(sl_en), .watchdog_clear(wd_cl), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.status_out(status_out));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ==========
	// tasks
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task chk(input string name, input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// status moves at the completing edge; looked at two falling edges later
	task chk_st(input logic [7:0] e);
		repeat (2) @(negedge pclk);
		n_checks++;
		if (status_out !== e) begin
			n_mismatch++;
			$display("mismatch status_out expected %h seen %h", e, status_out);
		end
	endtask : chk_st

	// read right after the rising edge, before any flop updates, so these are the sampled values
	task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, {idx, WORD_ALIGN}, {24'h0, d});
	endtask : wr

	task rd(input logic [9:0] idx, input logic [7:0] e);
		apb(1'b0, {idx, WORD_ALIGN}, 32'h0);
		chk("prdata", {errv, rdv}, {25'h0, e});
	endtask : rd

	task ex(input op_e op, input logic tf, input logic [2:0] bs, input logic [6:0] fa, input logic [7:0] lit);
		apb(1'b1, {IDX_INSTR, WORD_ALIGN}, {9'h0, op, tf, bs, fa, lit});
	endtask : ex

	// bus write to status keeps the cause flags
	task wst(input logic [7:0] d);
		st = (d & 8'hE7) | (st & 8'h18);
		wr(10'h183, d);
	endtask : wst

	function automatic logic [10:0] alu(input logic [7:0] x, input logic [7:0] y, input logic sub);
		logic [8:0] s;
		logic [4:0] n;
		s = sub ? {1'b0, x} + {1'b0, ~y} + 9'h1 : {1'b0, x} + {1'b0, y};
		n = sub ? {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h1 : {1'b0, x[3:0]} + {1'b0, y[3:0]};
		return {s[7:0] == 8'h0, n[4], s[8], s[7:0]};
	endfunction : alu

	// ==========
	// tests
	initial begin
		{presetn, psel, penable, pwrite, wd_to, sl_en, wd_cl} = 7'h0;
		paddr = '0;
		pwdata = '0;
		n_mismatch = 0;
		n_checks = 0;
		void'($urandom(66409));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		st = 8'h18;
		chk_st(st);
		for (int i = 0; i < 8; i++) rd(ri[i], rv[i]);
		$display("test reset done");

		rd(10'h185, 8'h00);
		wr(10'h18A, 8'hFF);
		rd(10'h18A, 8'h1F);
		apb(1'b1, 12'h60D, 32'hFF);
		chk("pslverr", {32'h0, errv}, 33'h1);
		rd(10'h183, st);
		apb(1'b0, 12'h808, 32'h0);
		chk("prdata", {errv, rdv}, {1'b1, 32'h0});
		$display("test unmapped done");

		wst(8'hE0);
		for (int k = 0; k < 4; k++) rd({1'b0, 2'(k), 7'h03}, st);
		for (int k = 0; k < 4; k++) begin
			wst({1'b0, 2'(k), 5'h0});
			w = 8'($urandom);
			wr(IDX_WORKING, w);
			ex(OP_MOVE_W_TO_FILE, 1'b1, 3'h0, 7'h04, 8'h00);
			rd({1'b0, 2'(k), 7'h04}, k == 3 ? w : 8'h00);
			rd({1'b0, IDX_INDIRECT_POINTER}, k == 3 ? w : 8'h00);
		end
		w = 8'($urandom);
		wr(IDX_WORKING, w);
		ex(OP_MOVE_W_TO_FILE, 1'b1, 3'h0, 7'h03, 8'h00);
		st = (w & 8'hE7) | (st & 8'h18);
		chk_st(st);
		$display("test banks done");

		for (int k = 0; k < 16; k++) begin
			ex(k < 8 ? OP_BIT_SET : OP_BIT_CLEAR, 1'b1, 3'(k), 7'h03, 8'h00);
			if (k % 8 != 3 && k % 8 != 4) st[k % 8] = (k < 8);
			chk_st(st);
		end
		wst(8'h25);
		ex(OP_NIBBLE_SWAP, 1'b1, 3'h0, 7'h03, 8'h00);
		st = ({st[3:0], st[7:4]} & 8'hE7) | (st & 8'h18);
		chk_st(st);
		wst(8'hFF);
		ex(OP_CLEAR_FILE, 1'b1, 3'h0, 7'h03, 8'h00);
		st = (st & 8'h1B) | 8'h04;
		rd(10'h183, st);
		$display("test status writes done");

		for (int k = 0; k < 12; k++) begin
			a = 8'($urandom);
			b = (k == 0) ? a : 8'($urandom);
			wst(8'h60);
			wr(10'h18B, a);
			ex(OP_MOVE_LITERAL, 1'b0, 3'h0, 7'h00, b);
			rd(IDX_WORKING, b);
			ex(OP_SUBTRACT_FILE, 1'b0, 3'h0, 7'h0B, 8'h00);
			{f, w} = alu(a, b, 1'b1);
			st[2:0] = f;
			rd(IDX_WORKING, w);
			chk_st(st);
			ex(OP_SUBTRACT_LITERAL, 1'b0, 3'h0, 7'h00, b);
			{f, w} = alu(b, w, 1'b1);
			st[2:0] = f;
			rd(IDX_WORKING, w);
			wst(a);
			ex(OP_ADD_FILE, 1'b1, 3'h0, 7'h03, 8'h00);
			{f, r8} = alu(st, w, 1'b0);
			st = (r8 & 8'hE0) | (st & 8'h18) | {5'h0, f};
			chk_st(st);
		end
		$display("test arithmetic done");

		wst(8'h80);
		wr({1'b0, IDX_INDIRECT_POINTER}, 8'h86);
		a = 8'($urandom);
		wr({1'b0, IDX_INDIRECT_PORT}, a);
		rd(10'h186, a);
		rd({1'b0, IDX_INDIRECT_PORT}, a);
		w = 8'($urandom);
		wr(IDX_WORKING, w);
		ex(OP_MOVE_W_TO_FILE, 1'b1, 3'h0, 7'h00, 8'h00);
		rd(10'h186, w);
		wr({1'b0, IDX_INDIRECT_POINTER}, 8'h80);
		rd({1'b0, IDX_INDIRECT_PORT}, 8'h00);
		$display("test indirect done");

		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			{wd_to, sl_en, wd_cl} <= 3'b100 >> k;
			@(posedge pclk);
			{wd_to, sl_en, wd_cl} <= 3'b000;
			st[4:3] = (k == 0) ? {1'b0, st[3]} : ((k == 1) ? 2'b10 : 2'b11);
			chk_st(st);
		end
		$display("test cause flags done");

		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		st = 8'h18;
		chk_st(st);
		rd({1'b0, IDX_INDIRECT_POINTER}, 8'h00);
		$display("test mid-run reset done");
		results();
	end

	// far beyond the expected run of about nine hundred cycles
	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		$display("mismatch watchdog expected finish seen timeout");
		results();
	end

endmodule : core_status_and_sfr_bank_bench

`default_nettype wire

//--- flag_alu.sv
// adder/subtractor producing result and the three arithmetic flags
`default_nettype none

module flag_alu
	import sfr_bank_pkg::*;
(
	input wire logic [7:0] a, // first operand
	input wire logic [7:0] b, // second operand
	input wire logic subtract, // a minus b when high
	output logic [7:0] sum, // result
	output logic carry, // carry, or inverted borrow
	output logic digit_carry, // low nibble carry, or inverted digit borrow
	output logic zero // result is zero
);

	logic [7:0] b_eff;
	logic [8:0] full;
	logic [4:0] low;

	// subtraction as a + ~b + 1 so the carries come out as inverted borrows
	assign b_eff = subtract ? ~b : b;
	assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, subtract};
	assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, subtract};
	assign sum = full[7:0];
	assign carry = full[8];
	assign digit_carry = low[4];
	assign zero = (full[7:0] == BYTE_ZERO);

endmodule : flag_alu

`default_nettype wire

//--- sfr_bank_pkg.sv
// constants, types and register map for the core status and sfr bank
`default_nettype none

package sfr_bank_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ==========================================================
	// register indexes (byte address = index * 4)
	localparam logic [9:0] IDX_DATA_END = 10'h200;
	localparam logic [9:0] IDX_INSTR = 10'h200;
	localparam logic [9:0] IDX_WORKING = 10'h201;
	localparam logic [8:0] IDX_INDIRECT_PORT = 9'h180;
	localparam logic [8:0] IDX_TIMER_OPTION = 9'h181;
	localparam logic [8:0] IDX_PC_LOW = 9'h182;
	localparam logic [8:0] IDX_CORE_STATUS = 9'h183;
	localparam logic [8:0] IDX_INDIRECT_POINTER = 9'h184;
	localparam logic [8:0] IDX_PIN_DIRECTION_B = 9'h186;
	localparam logic [8:0] IDX_PC_HIGH_LATCH = 9'h18A;
	localparam logic [8:0] IDX_INTERRUPT_CONTROL = 9'h18B;

	// ==========================================================
	// bank map
	localparam logic [6:0] STATUS_LOW7 = 7'h03;
	localparam logic [6:0] PORT_LOW7 = 7'h00;
	localparam logic [8:0] SFR_BASE = 9'h180;
	localparam int SFR_NUM = 12;
	localparam logic [3:0] SFR_LAST = 4'hB;
	localparam logic [3:0] SLOT_POINTER = 4'h4;
	localparam logic [3:0] SLOT_DIRECTION_B = 4'h6;
	localparam logic [7:0] SFR_MASK [SFR_NUM] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00,
		8'hFF, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hFF};
	localparam logic [7:0] SFR_RESET [SFR_NUM] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ==========================================================
	// types
	typedef struct packed {
		logic indirect_bank_select;
		logic direct_bank_select_high;
		logic direct_bank_select_low;
		logic watchdog_expiry_flag;
		logic sleep_entry_flag;
		logic zero_flag;
		logic nibble_overflow_flag;
		logic carry_flag;
	} status_s;

	typedef enum logic [3:0] {
		OP_MOVE_LITERAL,
		OP_MOVE_W_TO_FILE,
		OP_CLEAR_FILE,
		OP_ADD_FILE,
		OP_SUBTRACT_FILE,
		OP_SUBTRACT_LITERAL,
		OP_BIT_CLEAR,
		OP_BIT_SET,
		OP_NIBBLE_SWAP
	} op_e;

	typedef struct packed {
		op_e op;
		logic to_file;
		logic [2:0] bit_sel;
		logic [6:0] file_addr;
		logic [7:0] literal;
	} instr_s;

	localparam int INSTR_W = $bits(instr_s);

endpackage : sfr_bank_pkg

`default_nettype wire
